// *** rtl/kwu_pkg.sv ***
// Purpose: Shared constants and types for the key-on wakeup halt release block.
// Assumes: 8-bit register port, one system clock.
// Notes: Offsets are byte addresses on the plain register port.
package kwu_pkg;
   localparam int KWU_ADDR_W = 8;
   localparam int KWU_DATA_W = 8;
   localparam int KWU_KEYS = 4;
   localparam logic [7:0] KWU_OFS_ENABLE = 8'h31;
   localparam logic [7:0] KWU_OFS_STATUS = 8'h32;
   localparam int KWU_EN_LSB = 4;
   localparam int KWU_EN_MSB = 7;
   localparam logic [3:0] KWU_EN_RST = 4'h0;
   localparam logic [7:0] KWU_RD_ZERO = 8'h00;
   localparam int KWU_ST_HALT_BIT = 0;
   localparam int KWU_ST_WARM_BIT = 1;
   localparam int KWU_ST_MASK_BIT = 2;
   localparam int KWU_MASK_INSTR = 3;
   localparam int KWU_CNT_W = 16;
   localparam logic [15:0] KWU_CNT_ZERO = 16'h0000;
   localparam logic [15:0] KWU_CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {
      KWU_RUN,
      KWU_MASKED,
      KWU_HALTED,
      KWU_WARMUP
   } kwu_state_t;

   typedef struct packed {
      logic [KWU_ADDR_W-1:0] addr;
      logic [KWU_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } kwu_bus_req_t;

   typedef struct packed {
      kwu_state_t st;
      logic [KWU_KEYS-1:0] key_en;
      logic [KWU_KEYS-1:0] key_s1;
      logic [KWU_KEYS-1:0] key_s2;
      logic [KWU_KEYS-1:0] key_prev;
      logic exit_s1;
      logic exit_s2;
      logic exit_prev;
      logic [KWU_CNT_W-1:0] cnt;
      logic resume;
      logic [KWU_DATA_W-1:0] rdata;
   } kwu_state_reg_t;
endpackage

// *** rtl/kwu_wakeup.sv ***
// Purpose: Key-on wakeup logic that releases the core from its deepest halt mode.
// Assumes: Key pins and the halt-exit pin are asynchronous; halt entry and the
//    release method come from system control logic on the same clock.
// Notes: The enable register is write-only and reads back as zero.
`timescale 1ns/100ps

// Functional notes
// RULE_01: Enable bits 7..4 gate the four keys.
// RULE_02: Key enables clear to zero at reset.
// RULE_03: Software sets key pins as inputs first.
// RULE_04: Any edge on enabled key releases halt.
// RULE_05: Release request ORs exit pin and keys.
// RULE_06: Halt entered only by system control request.
// RULE_07: Software selects level release method for keys.
// RULE_08: Exit pin low, keys steady until wake.
// RULE_09: Exit-pin edge release needs keys disabled/fixed.
// RULE_10: Exit pin: high level or rising edge.
// RULE_11: Key release only in level mode.
// RULE_12: Request ignored three instruction cycles after halt.
// RULE_13: Oscillator warm-up precedes resumed execution.
// RULE_14: Low enable bits ignored; reads return zero.
module kwu_wakeup import kwu_pkg::*; #(
   parameter int INSTR_CLKS = 4,
   parameter int WARMUP_CLKS = 16
) (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // Register port.
   input wire logic [KWU_ADDR_W-1:0] reg_addr_in,
   input wire logic [KWU_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [KWU_DATA_W-1:0] reg_rdata_out,
   // System control.
   input wire logic halt_enter_in,
   input wire logic release_method_select_in,
   // Pins.
   input wire logic [KWU_KEYS-1:0] key_wake_pin_in,
   input wire logic halt_exit_pin_in,
   // Status.
   output logic halted_out,
   output logic release_req_out,
   output logic resume_out
);
   localparam logic [KWU_CNT_W-1:0] MASK_CNT = KWU_CNT_W'(KWU_MASK_INSTR * INSTR_CLKS);
   localparam logic [KWU_CNT_W-1:0] WARM_CNT = KWU_CNT_W'(WARMUP_CLKS);

   kwu_state_reg_t s_reg, s_next;
   kwu_bus_req_t bus;
   logic [KWU_KEYS-1:0] key_edge;
   logic exit_term, key_term;

   assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

   function automatic logic hit(input logic [KWU_ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < KWU_KEYS; gi++) begin : g_key
         // Either edge on an enabled key.
         assign key_edge[gi] = s_reg.key_en[gi] & (s_reg.key_s2[gi] ^ s_reg.key_prev[gi]); // RULE_04 RULE_01
      end
   endgenerate

   // Exit pin: high level in level mode, rising edge in edge mode.
   assign exit_term = release_method_select_in ? s_reg.exit_s2
                                               : (s_reg.exit_s2 & ~s_reg.exit_prev); // RULE_10
   assign key_term = release_method_select_in & (|key_edge); // RULE_11
   assign release_req_out = exit_term | key_term; // RULE_05

   always_comb begin
      s_next = s_reg;
      s_next.key_s1 = key_wake_pin_in;
      s_next.key_s2 = s_reg.key_s1;
      s_next.key_prev = s_reg.key_s2;
      s_next.exit_s1 = halt_exit_pin_in;
      s_next.exit_s2 = s_reg.exit_s1;
      s_next.exit_prev = s_reg.exit_s2;
      s_next.resume = 1'b0;
      s_next.rdata = KWU_RD_ZERO;
      if (bus.wr && hit(bus.addr, KWU_OFS_ENABLE)) begin
         s_next.key_en = bus.wdata[KWU_EN_MSB:KWU_EN_LSB]; // RULE_01 RULE_14
      end
      if (bus.rd && hit(bus.addr, KWU_OFS_STATUS)) begin
         s_next.rdata[KWU_ST_HALT_BIT] = (s_reg.st != KWU_RUN);
         s_next.rdata[KWU_ST_WARM_BIT] = (s_reg.st == KWU_WARMUP);
         s_next.rdata[KWU_ST_MASK_BIT] = (s_reg.st == KWU_MASKED);
      end
      unique case (s_reg.st)
         KWU_RUN: begin
            if (halt_enter_in) begin
               s_next.st = KWU_MASKED; // RULE_06
               s_next.cnt = MASK_CNT - KWU_CNT_ONE;
            end
         end
         KWU_MASKED: begin
            // Requests are ignored here.
            if (s_reg.cnt == KWU_CNT_ZERO) begin
               s_next.st = KWU_HALTED; // RULE_12
            end else begin
               s_next.cnt = s_reg.cnt - KWU_CNT_ONE;
            end
         end
         KWU_HALTED: begin
            if (release_req_out) begin
               s_next.st = KWU_WARMUP; // RULE_13
               s_next.cnt = WARM_CNT - KWU_CNT_ONE;
            end
         end
         KWU_WARMUP: begin
            if (s_reg.cnt == KWU_CNT_ZERO) begin
               s_next.st = KWU_RUN;
               s_next.resume = 1'b1; // RULE_13
            end else begin
               s_next.cnt = s_reg.cnt - KWU_CNT_ONE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_reg <= '0;
         s_reg.st <= KWU_RUN;
         s_reg.key_en <= KWU_EN_RST; // RULE_02
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_out = s_reg.rdata;
   assign halted_out = (s_reg.st != KWU_RUN);
   assign resume_out = s_reg.resume;

   // Helper: cycles spent in the masked state.
   logic [KWU_CNT_W-1:0] mask_seen;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || s_reg.st != KWU_MASKED) begin
         mask_seen <= KWU_CNT_ZERO;
      end else begin
         mask_seen <= mask_seen + KWU_CNT_ONE;
      end
   end

   enable_reset_a: assert property (@(posedge clk_sys_in)
      sys_rst_in |=> s_reg.key_en == KWU_EN_RST) else $error("enables not cleared"); // RULE_02
   enable_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_wr_in && reg_addr_in == KWU_OFS_ENABLE)
      |=> s_reg.key_en == $past(reg_wdata_in[KWU_EN_MSB:KWU_EN_LSB]))
      else $error("enable write lost"); // RULE_01
   enable_readback_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_rd_in && reg_addr_in == KWU_OFS_ENABLE) |=> reg_rdata_out == KWU_RD_ZERO)
      else $error("write-only register read nonzero"); // RULE_14
   key_edge_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (release_method_select_in && |(s_reg.key_en & (s_reg.key_s2 ^ s_reg.key_prev)))
      |-> release_req_out) else $error("enabled key edge missed"); // RULE_04
   or_form_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (release_method_select_in && s_reg.exit_s2) |-> release_req_out)
      else $error("exit level not in request"); // RULE_05
   edge_mode_keys_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (!release_method_select_in && !(s_reg.exit_s2 && !s_reg.exit_prev)) |-> !release_req_out)
      else $error("key release in edge mode"); // RULE_11 RULE_10
   halt_entry_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (s_reg.st == KWU_RUN && !halt_enter_in) |=> s_reg.st == KWU_RUN)
      else $error("halt without request"); // RULE_06
   mask_len_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (s_reg.st == KWU_RUN && halt_enter_in)
      |=> (s_reg.st == KWU_MASKED) && mask_seen == KWU_CNT_ZERO)
      else $error("mask not entered"); // RULE_12
   mask_exit_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (s_reg.st == KWU_MASKED && $past(s_reg.st) == KWU_MASKED && s_reg.cnt == KWU_CNT_ZERO)
      |-> mask_seen == MASK_CNT - KWU_CNT_ONE) else $error("mask length wrong"); // RULE_12
   warmup_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (s_reg.st == KWU_HALTED && release_req_out) |=> s_reg.st == KWU_WARMUP && !resume_out)
      else $error("no warm-up after release"); // RULE_13
   resume_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      resume_out |-> $past(s_reg.st) == KWU_WARMUP && s_reg.st == KWU_RUN)
      else $error("resume without warm-up"); // RULE_13

   key_wake_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      s_reg.st == KWU_HALTED && key_term);
   exit_wake_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      s_reg.st == KWU_HALTED && exit_term);
   masked_req_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      s_reg.st == KWU_MASKED && release_req_out);
   resume_c: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) resume_out);
endmodule // kwu_wakeup

// *** sim/kwu_pin_model.sv ***
// Purpose: Model of the key switches and the halt-exit signal source.
// Assumes: The bench asks for pin levels; the model moves the pins.
// Notes: Pins change just after a rising edge and hold steady between presses.
`timescale 1ns/100ps
module kwu_pin_model import kwu_pkg::*; (
   // Clock.
   input wire logic clk_sys_in,
   // Requested levels.
   input wire logic [KWU_KEYS-1:0] key_level_in,
   input wire logic exit_level_in,
   // Pins.
   output logic [KWU_KEYS-1:0] key_wake_pin_out,
   output logic halt_exit_pin_out
);
   // One process owns the pins; they settle at the first edge, well inside reset.
   always @(posedge clk_sys_in) begin
      key_wake_pin_out <= #1 key_level_in;
      halt_exit_pin_out <= #1 exit_level_in;
   end
endmodule // kwu_pin_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the key-on wakeup block.
// Assumes: Warm-up shortened to 2 clocks; mask is 3 instruction cycles of 4 clocks.
// Notes: Pins reach the block through the switch model.
`timescale 1ns/100ps
module tb;
   import kwu_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, halt = 1'b0, release_method_select = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0] key_lvl = 4'h0, keys;
   logic exit_lvl = 1'b0, exitp, halted, req, resume;
   localparam int WARM = 2;
   int fails = 0, checked = 0, cyc = 0, n;
   always #5 clk = ~clk;
   kwu_pin_model pins (.clk_sys_in(clk), .key_level_in(key_lvl), .exit_level_in(exit_lvl),
      .key_wake_pin_out(keys), .halt_exit_pin_out(exitp));
   kwu_wakeup #(.INSTR_CLKS(4), .WARMUP_CLKS(WARM)) dut (.clk_sys_in(clk), .sys_rst_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .halt_enter_in(halt), .release_method_select_in(release_method_select),
      .key_wake_pin_in(keys), .halt_exit_pin_in(exitp), .halted_out(halted),
      .release_req_out(req), .resume_out(resume));
   task automatic print_verdict();
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic halt_now();
      @(posedge clk); halt <= 1'b1;
      @(posedge clk); halt <= 1'b0;
      #1 check({7'h0, halted}, 8'h01);
   endtask
   task automatic wait_resume(input int lim);
      n = 0;
      while (resume !== 1'b1 && n < lim) begin
         @(posedge clk); #1; n++;
      end
   endtask
   // Register defaults, write-only readback and an unmapped address.
   task automatic t_regs();
      bus_rd(KWU_OFS_ENABLE, 8'h00);
      bus_wr(KWU_OFS_ENABLE, 8'h0f);
      bus_rd(KWU_OFS_ENABLE, 8'h00);
      bus_rd(8'h7e, 8'h00);
      bus_rd(KWU_OFS_STATUS, 8'h00);
   endtask
   // Key edge inside the mask is ignored; a later edge wakes after warm-up.
   task automatic t_key_wake();
      @(posedge clk);
      release_method_select <= 1'b1;
      bus_wr(KWU_OFS_ENABLE, 8'hf0);
      halt_now();
      key_lvl <= 4'h2;
      wait_resume(16);
      check({7'h0, resume}, 8'h00);
      bus_rd(KWU_OFS_STATUS, 8'h01);
      key_lvl <= 4'h0;
      wait_resume(30);
      check({7'h0, resume}, 8'h01);
      // Pin model edge, two sync stages and the release edge come before warm-up.
      check(8'(n), 8'(4 + WARM));
      check({7'h0, halted}, 8'h00);
   endtask
   // A disabled key cannot wake; the exit pin level still does.
   task automatic t_key_disabled();
      bus_wr(KWU_OFS_ENABLE, 8'h10);
      halt_now();
      bus_rd(KWU_OFS_STATUS, 8'h05);
      wait_resume(16);
      key_lvl <= 4'h4;
      wait_resume(20);
      check({7'h0, resume}, 8'h00);
      exit_lvl <= 1'b1;
      wait_resume(30);
      check({7'h0, resume}, 8'h01);
      check({7'h0, req}, 8'h01);
      exit_lvl <= 1'b0;
      key_lvl <= 4'h0;
   endtask
   // Edge mode: enabled keys do nothing, a rising exit edge wakes.
   task automatic t_edge_mode();
      @(posedge clk);
      release_method_select <= 1'b0;
      bus_wr(KWU_OFS_ENABLE, 8'hf0);
      halt_now();
      wait_resume(16);
      key_lvl <= 4'h8;
      wait_resume(20);
      check({7'h0, resume}, 8'h00);
      exit_lvl <= 1'b1;
      wait_resume(30);
      check({7'h0, resume}, 8'h01);
      // A steady high exit level is no request in edge mode.
      check({7'h0, req}, 8'h00);
      exit_lvl <= 1'b0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_key_wake();
      t_key_disabled();
      t_edge_mode();
      print_verdict();
   end
endmodule // tb
